// file: rtl/xaddr_cfg.svh
// constants for the extended address / emulation chip select block
// assumes a 16-bit core address and a 6-bit program page index
`ifndef XADDR_CFG_SVH
`define XADDR_CFG_SVH
`define XA_CODE_Q0     6'h3D
`define XA_CODE_Q1     6'h3E
`define XA_CODE_Q3     6'h3F
`define XA_QUAD_HI     15
`define XA_QUAD_LO     14
`define XA_SW_00_BASE  6'h38
`define XA_SW_01_BASE  6'h30
`define XA_SW_10_BASE  6'h20
`define XA_SW_11_BASE  6'h00
`define XA_CS_IDLE     1'b1
`define XA_LINES_RST   6'h00
`endif

// file: rtl/xaddr_pkg.sv
// types for the extended address / emulation chip select block
// assumes nothing beyond the cfg header
package xaddr_pkg;
  typedef enum logic [1:0] {
    alloc_0k  = 2'b00,
    alloc_16k = 2'b01,
    alloc_48k = 2'b10,
    alloc_64k = 2'b11
  } alloc_type;
  typedef enum logic [1:0] {
    quad_low  = 2'b00,
    quad_mid  = 2'b01,
    quad_page = 2'b10,
    quad_top  = 2'b11
  } quad_type;
endpackage

// file: rtl/page_window_class.sv
// classifies a page index as internal or external to the window
// assumes paging switches are static straps from system integration
`timescale 1ns/1ps
`include "xaddr_cfg.svh"
module page_window_class (
  input  wire logic [1:0] paging_config_switches,
  input  wire logic [5:0] page_index_bits,
  output logic            page_internal
);
  logic [5:0] base;
  // ----------------------------------------
  // lowest internal page per partitioning
  // ----------------------------------------
  always_comb begin
    unique case (paging_config_switches)
      2'b00: base = `XA_SW_00_BASE;
      2'b01: base = `XA_SW_01_BASE;
      2'b10: base = `XA_SW_10_BASE;
      2'b11: base = `XA_SW_11_BASE;
    endcase
  end
  assign page_internal = (page_index_bits >= base);
endmodule // page_window_class

// file: rtl/ext_addr_cs.sv
// extended address lines and emulation chip select for expanded modes
// assumes core_addr/page_index_bits valid each cycle; outputs lag 1 cycle except emu_chip_select_oe, which is not registered
`timescale 1ns/1ps
`include "xaddr_cfg.svh"
// How it works
// - page window access drives page index bits
// - index bit 5..0 on port K 5..0
// - fixed codes 3D 3E 3F outside window
// - chip select follows allocation and quadrant
// - 48K mid and 64K low/mid quadrants use rom high map
// - outputs valid only with enable and expanded, except emu_chip_select_oe, which follows enable alone
// - 0K: high low quadrants, low otherwise
// - 16K: low only in top quadrant
// - 48K: mid by map, window by internal
// - 64K: lows by map, window by internal
// - port K bit 7 is chip select
// - internal page from paging switches
module ext_addr_cs
  import xaddr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] core_addr,
  input  wire logic [5:0]  page_index_bits,
  input  wire logic [1:0]  paging_config_switches,
  input  wire alloc_type   flash_alloc,
  input  wire logic        rom_high_map_select,
  input  wire logic        emulation_port_k_enable,
  input  wire logic        expanded_mode,
  output logic [5:0]       extended_addr_lines,
  output logic             extended_addr_oe,
  output logic             emu_chip_select_n,
  output logic             emu_chip_select_oe
);
  quad_type   quad;
  logic       page_internal;
  logic       active;
  logic [5:0] lines_nxt;
  logic       cs_n_nxt;
  logic [5:0] lines_r;
  logic       cs_n_r;
  logic       act_r;

  page_window_class u_class (
    .paging_config_switches (paging_config_switches),
    .page_index_bits        (page_index_bits),
    .page_internal          (page_internal)
  );

  assign quad   = quad_type'(core_addr[`XA_QUAD_HI:`XA_QUAD_LO]);
  assign active = emulation_port_k_enable & expanded_mode;

  // ----------------------------------------
  // address line selection
  // ----------------------------------------
  always_comb begin
    unique case (quad)
      quad_low:  lines_nxt = `XA_CODE_Q0;
      quad_mid:  lines_nxt = `XA_CODE_Q1;
      quad_page: lines_nxt = page_index_bits;
      quad_top:  lines_nxt = `XA_CODE_Q3;
    endcase
  end

  // ----------------------------------------
  // chip select decode
  // ----------------------------------------
  always_comb begin
    cs_n_nxt = `XA_CS_IDLE;
    unique case (flash_alloc)
      alloc_0k:  cs_n_nxt = (quad == quad_low) | (quad == quad_mid);
      alloc_16k: cs_n_nxt = (quad != quad_top);
      alloc_48k: begin
        unique case (quad)
          quad_low:  cs_n_nxt = 1'b1;
          quad_mid:  cs_n_nxt = rom_high_map_select;
          quad_page: cs_n_nxt = ~page_internal;
          quad_top:  cs_n_nxt = 1'b0;
        endcase
      end
      alloc_64k: begin
        unique case (quad)
          quad_low:  cs_n_nxt = rom_high_map_select;
          quad_mid:  cs_n_nxt = rom_high_map_select;
          quad_page: cs_n_nxt = ~page_internal;
          quad_top:  cs_n_nxt = 1'b0;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // registered so the pins never glitch through the decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lines_r <= `XA_LINES_RST;
    end else if (active) begin
      lines_r <= lines_nxt;
    end else begin
      lines_r <= `XA_LINES_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_n_r <= `XA_CS_IDLE;
    end else if (active) begin
      cs_n_r <= cs_n_nxt;
    end else begin
      cs_n_r <= `XA_CS_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_r <= 1'b0;
    end else begin
      act_r <= active;
    end
  end

  // lines are parked at 00 with extended_addr_oe low when not active
  assign extended_addr_lines = lines_r;
  assign extended_addr_oe    = act_r;
  assign emu_chip_select_n   = cs_n_r;
  assign emu_chip_select_oe  = emulation_port_k_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_page_access;
    active && quad == quad_page;
  endsequence

  sequence s_low_access;
    active && quad == quad_low;
  endsequence

  sequence s_mid_access;
    active && quad == quad_mid;
  endsequence

  // the map bit only matters in the two large allocations
  sequence s_mid_mapped;
    s_mid_access ##0 (flash_alloc == alloc_48k || flash_alloc == alloc_64k)
      ##0 rom_high_map_select;
  endsequence

  a_page_index_out: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access |=> extended_addr_lines == $past(page_index_bits))
    else $error("page index not driven");
  a_code_low: assert property (
    @(posedge core_clk) disable iff (rst)
    s_low_access |=> extended_addr_lines == 6'h3D)
    else $error("wrong low quadrant code");
  a_code_mid: assert property (
    @(posedge core_clk) disable iff (rst)
    s_mid_access |=> extended_addr_lines == 6'h3E)
    else $error("wrong second quadrant code");
  a_code_top: assert property (
    @(posedge core_clk) disable iff (rst)
    active && quad == quad_top
      |=> extended_addr_lines == 6'h3F && !emu_chip_select_n)
    else $error("wrong top quadrant code or select");
  a_idle_high: assert property (
    @(posedge core_clk) disable iff (rst)
    !active |=> emu_chip_select_n && !extended_addr_oe)
    else $error("outputs not idle");
  a_idle_lines: assert property (
    @(posedge core_clk) disable iff (rst)
    !active |=> extended_addr_lines == 6'h00)
    else $error("lines not parked while idle");
  // the register was cleared by reset one edge ago, whatever active was
  a_oe_follows: assert property (
    @(posedge core_clk) disable iff (rst)
    extended_addr_oe == ($past(active) && !$past(rst)))
    else $error("enable mismatch");
  a_zero_alloc_cs: assert property (
    @(posedge core_clk) disable iff (rst)
    s_mid_access ##0 flash_alloc == alloc_0k |=> emu_chip_select_n)
    else $error("0K mid quadrant select low");
  a_zero_alloc_win: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 flash_alloc == alloc_0k |=> !emu_chip_select_n)
    else $error("0K window select high");
  a_sixteen_page: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 flash_alloc == alloc_16k |=> emu_chip_select_n)
    else $error("16K window select low");
  a_sixteen_low: assert property (
    @(posedge core_clk) disable iff (rst)
    s_low_access ##0 flash_alloc == alloc_16k |=> emu_chip_select_n)
    else $error("16K low quadrant select low");
  a_map_low: assert property (
    @(posedge core_clk) disable iff (rst)
    s_low_access ##0 flash_alloc == alloc_64k
      |=> emu_chip_select_n == $past(rom_high_map_select))
    else $error("64K low quadrant ignores map");
  a_map_mid: assert property (
    @(posedge core_clk) disable iff (rst)
    s_mid_access ##0 flash_alloc == alloc_64k
      |=> emu_chip_select_n == $past(rom_high_map_select))
    else $error("64K second quadrant ignores map");
  a_map_high: assert property (
    @(posedge core_clk) disable iff (rst)
    s_mid_mapped |=> emu_chip_select_n)
    else $error("high map leaves second quadrant selected");
  a_window_int: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 flash_alloc == alloc_48k
      |=> emu_chip_select_n == !$past(page_internal))
    else $error("48K window select wrong");
  a_mid_48k: assert property (
    @(posedge core_clk) disable iff (rst)
    s_mid_access ##0 flash_alloc == alloc_48k
      |=> emu_chip_select_n == $past(rom_high_map_select))
    else $error("48K second quadrant ignores map");
  a_low_48k: assert property (
    @(posedge core_clk) disable iff (rst)
    s_low_access ##0 flash_alloc == alloc_48k |=> emu_chip_select_n)
    else $error("48K low quadrant select low");
  a_window_64k: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 flash_alloc == alloc_64k
      |=> emu_chip_select_n == !$past(page_internal))
    else $error("64K window select wrong");
  a_switch_all_int: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 paging_config_switches == 2'b11
      ##0 flash_alloc == alloc_64k |=> !emu_chip_select_n)
    else $error("all-internal strap gave external page");
  a_switch_ext: assert property (
    @(posedge core_clk) disable iff (rst)
    s_page_access ##0 paging_config_switches == 2'b00
      ##0 flash_alloc == alloc_64k ##0 page_index_bits < `XA_SW_00_BASE
      |=> emu_chip_select_n)
    else $error("low page not external");
endmodule // ext_addr_cs

// file: verif/ext_mem_model.sv
// far-side model: external memory or emulator on the expansion bus
// assumes the pins of ext_addr_cs, sampled on core_clk
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       core_clk,
  input  wire logic [5:0] extended_addr_lines,
  input  wire logic       extended_addr_oe,
  input  wire logic       emu_chip_select_n,
  output logic      [5:0] seen_lines
);
  initial seen_lines = 6'h00;
  // an undriven or deselected cycle carries nothing, so it is ignored
  always @(posedge core_clk)
    if (!emu_chip_select_n && extended_addr_oe)
      seen_lines <= extended_addr_lines;
endmodule // ext_mem_model

// file: verif/ext_addr_cs_bench.sv
// self-checking bench for ext_addr_cs with the far-side model
// assumes one-cycle output latency; inputs change 2 ns after each edge
`timescale 1ns/1ps
module ext_addr_cs_bench;
  import xaddr_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1, map = 1'b0;
  logic        en = 1'b1, exm = 1'b1, aoe, cs_n, cs_oe;
  logic [15:0] addr = 16'h0000;
  logic [5:0]  pix = 6'h00, lines, seen;
  logic [1:0]  sw = 2'h0;
  alloc_type   alloc = alloc_0k;
  logic [5:0]  base [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
  int          fails = 0, n_compared = 0;
  always #50 core_clk = ~core_clk;
  ext_addr_cs i_dut (.core_clk(core_clk), .rst(rst), .core_addr(addr),
    .page_index_bits(pix), .paging_config_switches(sw),
    .flash_alloc(alloc), .rom_high_map_select(map),
    .emulation_port_k_enable(en), .expanded_mode(exm),
    .extended_addr_lines(lines), .extended_addr_oe(aoe),
    .emu_chip_select_n(cs_n), .emu_chip_select_oe(cs_oe));
  ext_mem_model i_mem (.core_clk(core_clk), .extended_addr_lines(lines),
    .extended_addr_oe(aoe), .emu_chip_select_n(cs_n), .seen_lines(seen));
  // ----
  // helpers
  // ----
  task automatic step;
    @(posedge core_clk);
    #2;
  endtask
  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk6({5'h00, got}, {5'h00, exp});
  endtask
  function automatic logic exp_cs(input logic [1:0] q, input logic intl);
    case (alloc)
      alloc_0k:  return q < 2'h2;
      alloc_16k: return q != 2'h3;
      alloc_48k: return (q == 2'h0) | (q == 2'h1 & map) | (q == 2'h2 & !intl);
      default:   return (q < 2'h2 & map) | (q == 2'h2 & !intl);
    endcase
  endfunction
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    repeat (6) step;
    chk6(lines, 6'h00);
    chk1(aoe, 1'b0);
    chk1(cs_n, 1'b1);
    rst = 1'b0;
  endtask
  task automatic t_table;
    logic [1:0] q;
    logic [5:0] xl;
    for (int k = 0; k < 64; k++) begin
      alloc = alloc_type'(k[5:4]);
      map = k[3];
      q = k[2:1];
      addr = {q, 14'h1234};
      pix = k[0] ? 6'h3A : 6'h37;
      xl = q == 2'h2 ? pix : {4'hF, q == 2'h3 ? 2'h3 : q + 2'h1};
      step;
      chk6(lines, xl);
      chk1(cs_n, exp_cs(q, k[0]));
      chk1(aoe, 1'b1);
      if (!exp_cs(q, k[0])) begin
        step;
        chk6(seen, xl);
      end
    end
  endtask
  task automatic t_switch;
    alloc = alloc_64k;
    addr = 16'h8000;
    for (int s = 0; s < 4; s++) begin
      sw = s[1:0];
      pix = base[s];
      step;
      chk1(cs_n, 1'b0);
      pix = base[s] - 6'h01;
      step;
      chk1(cs_n, s != 3);
    end
  endtask
  task automatic t_idle;
    addr = 16'hC000;
    for (int c = 0; c < 4; c++) begin
      {en, exm} = c[1:0];
      step;
      chk1(cs_oe, en);
      chk1(cs_n, c != 3);
      chk1(aoe, c == 3);
      chk6(lines, c == 3 ? 6'h3F : 6'h00);
    end
  endtask
  // reset again while the port is active, then resume
  task automatic t_rerun;
    rst = 1'b1;
    step;
    chk6(lines, 6'h00);
    chk1(aoe, 1'b0);
    chk1(cs_n, 1'b1);
    rst = 1'b0;
    step;
    chk6(lines, 6'h3F);
    chk1(cs_n, 1'b0);
    chk1(aoe, 1'b1);
  endtask
  task automatic final_report;
    $display("compared %0d, fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_reset;
    t_table;
    t_switch;
    t_idle;
    t_rerun;
    final_report;
  end
endmodule // ext_addr_cs_bench
